// file: mihu_consts.vh
// constants for the interrupt and halt unit: register indices,
// field masks, reset values and vector nibbles.
// assumes a byte address of four times the register index.
`ifndef MIHU_CONSTS_VH
`define MIHU_CONSTS_VH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define MIHU_IDX_KEY_SEL 16'hff20
`define MIHU_IDX_CORE_STAT 16'hff30
`define MIHU_IDX_PT_MASK 16'hffe2
`define MIHU_IDX_SER_MASK 16'hffe3
`define MIHU_IDX_KEY_MASK 16'hffe4
`define MIHU_IDX_CT_MASK 16'hffe6
`define MIHU_IDX_SW_MASK 16'hffe7
`define MIHU_IDX_PT_PEND 16'hfff2
`define MIHU_IDX_SER_PEND 16'hfff3
`define MIHU_IDX_KEY_PEND 16'hfff4
`define MIHU_IDX_CT_PEND 16'hfff6
`define MIHU_IDX_SW_PEND 16'hfff7

// ----------------------------------------------------------------
// implemented bits per register
// ----------------------------------------------------------------
`define MIHU_PT_BITS 4'h3
`define MIHU_SER_BITS 4'h1
`define MIHU_KEY_BITS 4'h1
`define MIHU_CT_BITS 4'hf
`define MIHU_SW_BITS 4'h3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MIHU_RST_MASK 10'h000
`define MIHU_RST_PEND 10'h000
`define MIHU_RST_KEY_SEL 4'h0

// ----------------------------------------------------------------
// vector low nibbles, high bits of the vector are fixed
// ----------------------------------------------------------------
`define MIHU_VEC_WDT 4'h0
`define MIHU_VEC_PT 4'h4
`define MIHU_VEC_SER 4'h6
`define MIHU_VEC_KEY 4'h8
`define MIHU_VEC_CT 4'hc
`define MIHU_VEC_SW 4'he

`endif

// file: mihu_edge.v
// edge detector bank for interrupt sources.
// assumes pin inputs need SYNC=1; same-clock levels use SYNC=0.
`timescale 1ns/1ps
module mihu_edge
#(
    parameter N = 4,
    parameter SYNC = 0,
    parameter FALL_ONLY = 1
)
(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // levels in, pulses out
    input wire [N-1:0] level_i,
    output wire [N-1:0] pulse_o
);

    genvar g;
    generate
        for (g = 0; g < N; g = g + 1)
        begin : bit_g
            wire cur;
            reg prev_q;
            if (SYNC != 0)
            begin : sync_g
                reg s1_q;
                reg s2_q;
                always @(posedge clk_i)
                begin
                    if (rst_i)
                    begin
                        s1_q <= 1'b0;
                        s2_q <= 1'b0;
                    end
                    else
                    begin
                        s1_q <= level_i[g];
                        s2_q <= s1_q;
                    end
                end
                assign cur = s2_q;
            end
            else
            begin : nosync_g
                assign cur = level_i[g];
            end
            always @(posedge clk_i)
            begin
                if (rst_i)
                    prev_q <= 1'b0;
                else
                    prev_q <= cur;
            end
            if (FALL_ONLY != 0)
            begin : fall_g
                assign pulse_o[g] = prev_q & ~cur;
            end
            else
            begin : any_g
                assign pulse_o[g] = prev_q ^ cur;
            end
        end
    endgenerate

endmodule

// file: mihu_prio.v
// fixed priority encoder over the six vector groups.
// assumes req_i bit 5 is the watchdog, bit 0 the stopwatch.
`timescale 1ns/1ps
`include "mihu_consts.vh"
module mihu_prio
(
    // group requests
    input wire [5:0] req_i,
    // winner
    output reg valid_o,
    output reg [3:0] vec_o
);

    always @*
    begin
        valid_o = |req_i;
        if (req_i[5])
            vec_o = `MIHU_VEC_WDT;
        else if (req_i[4])
            vec_o = `MIHU_VEC_PT;
        else if (req_i[3])
            vec_o = `MIHU_VEC_SER;
        else if (req_i[2])
            vec_o = `MIHU_VEC_KEY;
        else if (req_i[1])
            vec_o = `MIHU_VEC_CT;
        else
            vec_o = `MIHU_VEC_SW;
    end

endmodule

// file: mihu_top.v
// interrupt and halt unit of a small 4-bit controller core.
// assumes a classic wishbone master and a cpu on the same clock.
//
// Functional notes
// RULE_01 - maskable source interrupts only if pending, enabled and global enable set
// RULE_02 - accepting an interrupt clears the global enable flag
// RULE_03 - watchdog request ignores global enable, has no mask or flag
// RULE_04 - after reset all interrupts blocked until both stack pointers written
// RULE_05 - writing one stack pointer blocks interrupts until the other is written
// RULE_06 - halt stops the cpu while oscillator and timers keep running
// RULE_07 - any hardware request, watchdog included, restarts a halted cpu; code wakes only on the watchdog or an unmasked pending flag
// RULE_08 - timer zero, serial done, key edge, tap falls, stopwatch ticks set flags
// RULE_09 - writing one to a pending bit clears it
// RULE_10 - reset clears every pending flag and every mask bit
// RULE_11 - a flag left set raises its interrupt again when re-enabled
// RULE_12 - mask bits read and write; one enables, zero masks
// RULE_13 - each mask bit gates the flag at the same bit position
// RULE_14 - entry saves flags, clears enable, cpu pushes pc, loads vector
// RULE_15 - priority watchdog, timers, serial, key, clock timer, stopwatch
// RULE_16 - only the four low vector bits are supplied
// RULE_17 - entry starts only after the current instruction completes
// RULE_18 - shared vectors: handler reads pending flags to find the source
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "mihu_consts.vh"
module mihu_top
(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [17:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    // event sources
    input wire [1:0] prog_timer_zero_i,
    input wire serial_done_i,
    input wire [3:0] key_input_pins_i,
    input wire [3:0] clk_tap_i,
    input wire [1:0] stopwatch_tick_i,
    input wire wdt_nmi_i,
    // cpu side
    input wire instr_end_i,
    input wire halt_exec_i,
    input wire ie_set_i,
    input wire ie_clr_i,
    input wire return_from_interrupt_i,
    input wire return_from_interrupt_flag_i,
    input wire stack_ptr_one_wr_i,
    input wire stack_ptr_two_wr_i,
    output wire int_take_o,
    output wire [3:0] vector_lo_o,
    output wire saved_ie_o,
    output wire ie_flag_o,
    output wire cpu_halted_o,
    // interrupt line
    output wire irq_o
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function hit;
        input [17:0] adr;
        input [15:0] idx;
        begin
            hit = (adr[17:2] == idx) && (adr[1:0] == 2'b00);
        end
    endfunction

    reg ack_q;
    reg [31:0] dat_q;
    reg [9:0] mask_q;
    reg [9:0] mask_d;
    reg [9:0] pend_q;
    reg [9:0] pend_d;
    reg [3:0] key_sel_q;
    reg ie_q;
    reg ie_d;
    reg saved_ie_q;
    reg take_q;
    reg [3:0] vec_q;
    reg halted_q;
    reg nmi_q;
    reg sp_one_q;
    reg sp_two_q;
    reg irq_q;
    reg [31:0] rdat;

    wire acc;
    wire wr;
    wire [3:0] wd;
    wire [3:0] ct_fall;
    wire [3:0] key_edge;
    wire [9:0] set_ev;
    wire [9:0] live;
    wire sp_ok;
    wire [5:0] grp;
    wire win_valid;
    wire [3:0] win_vec;
    wire boundary;
    wire take;
    wire wake;

    assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr = acc & wb_we_i & wb_sel_i[0];
    assign wd = wb_dat_i[3:0];

    // ------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------
    mihu_edge
    #(
        .N(4),
        .SYNC(0),
        .FALL_ONLY(1)
    )
    u_tap
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .level_i(clk_tap_i),
        .pulse_o(ct_fall)
    );

    mihu_edge
    #(
        .N(4),
        .SYNC(1),
        .FALL_ONLY(0)
    )
    u_key
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .level_i(key_input_pins_i),
        .pulse_o(key_edge)
    );

    // pending bit order: pt[1:0], ser, key, ct[7:4], sw[9:8]
    assign set_ev = {stopwatch_tick_i, ct_fall,
                     |(key_edge & key_sel_q), serial_done_i,
                     prog_timer_zero_i}; // RULE_08

    // ------------------------------------------------------------
    // mask and pending registers
    // ------------------------------------------------------------
    always @*
    begin
        mask_d = mask_q;
        pend_d = pend_q;
        if (wr)
        begin
            if (hit(wb_adr_i, `MIHU_IDX_PT_MASK))
                mask_d[1:0] = wd[1:0]; // RULE_12
            if (hit(wb_adr_i, `MIHU_IDX_SER_MASK))
                mask_d[2] = wd[0]; // RULE_12
            if (hit(wb_adr_i, `MIHU_IDX_KEY_MASK))
                mask_d[3] = wd[0]; // RULE_12
            if (hit(wb_adr_i, `MIHU_IDX_CT_MASK))
                mask_d[7:4] = wd; // RULE_12
            if (hit(wb_adr_i, `MIHU_IDX_SW_MASK))
                mask_d[9:8] = wd[1:0]; // RULE_12
            if (hit(wb_adr_i, `MIHU_IDX_PT_PEND))
                pend_d[1:0] = pend_d[1:0] & ~wd[1:0]; // RULE_09
            if (hit(wb_adr_i, `MIHU_IDX_SER_PEND))
                pend_d[2] = pend_d[2] & ~wd[0]; // RULE_09
            if (hit(wb_adr_i, `MIHU_IDX_KEY_PEND))
                pend_d[3] = pend_d[3] & ~wd[0]; // RULE_09
            if (hit(wb_adr_i, `MIHU_IDX_CT_PEND))
                pend_d[7:4] = pend_d[7:4] & ~wd; // RULE_09
            if (hit(wb_adr_i, `MIHU_IDX_SW_PEND))
                pend_d[9:8] = pend_d[9:8] & ~wd[1:0]; // RULE_09
        end
        // a new event wins over a clear in the same cycle
        pend_d = pend_d | set_ev; // RULE_08
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mask_q <= `MIHU_RST_MASK; // RULE_10
            pend_q <= `MIHU_RST_PEND; // RULE_10
            key_sel_q <= `MIHU_RST_KEY_SEL;
        end
        else
        begin
            mask_q <= mask_d;
            pend_q <= pend_d;
            if (wr && hit(wb_adr_i, `MIHU_IDX_KEY_SEL))
                key_sel_q <= wd;
        end
    end

    assign live = pend_q & mask_q; // RULE_13

    // ------------------------------------------------------------
    // stack pointer interlock
    // ------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sp_one_q <= 1'b0; // RULE_04
            sp_two_q <= 1'b0; // RULE_04
        end
        else if (stack_ptr_one_wr_i || stack_ptr_two_wr_i)
        begin
            sp_one_q <= stack_ptr_one_wr_i |
                        (sp_one_q & ~sp_two_q); // RULE_05
            sp_two_q <= stack_ptr_two_wr_i |
                        (sp_two_q & ~sp_one_q); // RULE_05
        end
    end

    assign sp_ok = sp_one_q & sp_two_q; // RULE_04

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    assign grp[5] = nmi_q; // RULE_03
    assign grp[4] = ie_q & (|live[1:0]); // RULE_01
    assign grp[3] = ie_q & live[2]; // RULE_01
    assign grp[2] = ie_q & live[3]; // RULE_01
    assign grp[1] = ie_q & (|live[7:4]); // RULE_01
    assign grp[0] = ie_q & (|live[9:8]); // RULE_01

    mihu_prio u_prio
    (
        .req_i(grp),
        .valid_o(win_valid),
        .vec_o(win_vec)
    ); // RULE_15

    // a halted cpu sits between instructions
    assign boundary = instr_end_i | halted_q; // RULE_17
    // flags left set win again once enable returns
    assign take = sp_ok & win_valid & boundary & ~take_q; // RULE_11
    assign wake = sp_ok & (nmi_q | (|live)); // RULE_07

    // ------------------------------------------------------------
    // interrupt entry and halt
    // ------------------------------------------------------------
    always @*
    begin
        ie_d = ie_q;
        if (ie_set_i)
            ie_d = 1'b1;
        if (ie_clr_i)
            ie_d = 1'b0;
        if (return_from_interrupt_i)
            ie_d = return_from_interrupt_flag_i;
        if (take)
            ie_d = 1'b0; // RULE_02
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ie_q <= 1'b0;
            saved_ie_q <= 1'b0;
            take_q <= 1'b0;
            vec_q <= `MIHU_VEC_WDT;
            halted_q <= 1'b0;
            nmi_q <= 1'b0;
        end
        else
        begin
            ie_q <= ie_d;
            take_q <= take;
            if (take)
            begin
                saved_ie_q <= ie_q; // RULE_14
                vec_q <= win_vec; // RULE_16
            end
            // watchdog request held until served
            if (wdt_nmi_i)
                nmi_q <= 1'b1; // RULE_03
            else if (take && (win_vec == `MIHU_VEC_WDT))
                nmi_q <= 1'b0;
            // halt only parks the cpu, clocks stay running
            if (wake)
                halted_q <= 1'b0; // RULE_07
            else if (halt_exec_i)
                halted_q <= 1'b1; // RULE_06
        end
    end

    // ------------------------------------------------------------
    // bus read and answer
    // ------------------------------------------------------------
    always @*
    begin
        rdat = 32'h0000_0000;
        if (hit(wb_adr_i, `MIHU_IDX_PT_MASK))
            rdat[3:0] = {2'b00, mask_q[1:0]} & `MIHU_PT_BITS;
        else if (hit(wb_adr_i, `MIHU_IDX_SER_MASK))
            rdat[3:0] = {3'b000, mask_q[2]} & `MIHU_SER_BITS;
        else if (hit(wb_adr_i, `MIHU_IDX_KEY_MASK))
            rdat[3:0] = {3'b000, mask_q[3]} & `MIHU_KEY_BITS;
        else if (hit(wb_adr_i, `MIHU_IDX_CT_MASK))
            rdat[3:0] = mask_q[7:4] & `MIHU_CT_BITS;
        else if (hit(wb_adr_i, `MIHU_IDX_SW_MASK))
            rdat[3:0] = {2'b00, mask_q[9:8]} & `MIHU_SW_BITS;
        else if (hit(wb_adr_i, `MIHU_IDX_PT_PEND))
            rdat[3:0] = {2'b00, pend_q[1:0]} & `MIHU_PT_BITS;
        else if (hit(wb_adr_i, `MIHU_IDX_SER_PEND))
            rdat[3:0] = {3'b000, pend_q[2]} & `MIHU_SER_BITS;
        else if (hit(wb_adr_i, `MIHU_IDX_KEY_PEND))
            rdat[3:0] = {3'b000, pend_q[3]} & `MIHU_KEY_BITS;
        else if (hit(wb_adr_i, `MIHU_IDX_CT_PEND))
            rdat[3:0] = pend_q[7:4] & `MIHU_CT_BITS;
        else if (hit(wb_adr_i, `MIHU_IDX_SW_PEND))
            rdat[3:0] = {2'b00, pend_q[9:8]} & `MIHU_SW_BITS;
        else if (hit(wb_adr_i, `MIHU_IDX_KEY_SEL))
            rdat[3:0] = key_sel_q;
        else if (hit(wb_adr_i, `MIHU_IDX_CORE_STAT))
            rdat[3:0] = {nmi_q, halted_q, sp_ok, ie_q};
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
            irq_q <= 1'b0;
        end
        else
        begin
            ack_q <= acc;
            if (acc && !wb_we_i)
                dat_q <= rdat;
            irq_q <= |(pend_d & mask_d); // RULE_13
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign int_take_o = take_q;
    assign vector_lo_o = vec_q;
    assign saved_ie_o = saved_ie_q;
    assign ie_flag_o = ie_q;
    assign cpu_halted_o = halted_q;
    assign irq_o = irq_q;

endmodule

// file: mihu_top_chk.sv
// checker for the interrupt and halt unit top ports.
// assumes bind onto mihu_top, one clock, synchronous reset.
`timescale 1ns/1ps
module mihu_top_chk
(
    // watched ports
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire [31:0] wb_dat_o,
    input wire instr_end_i,
    input wire halt_exec_i,
    input wire stack_ptr_one_wr_i,
    input wire stack_ptr_two_wr_i,
    input wire int_take_o,
    input wire [3:0] vector_lo_o,
    input wire saved_ie_o,
    input wire ie_flag_o,
    input wire cpu_halted_o
);
    // ------------------------------------------
    // stack pointer pairing model
    // ------------------------------------------
    reg half1_q;
    reg half2_q;
    reg sp_ok_q;
    wire pair_w = (stack_ptr_one_wr_i && (half2_q || stack_ptr_two_wr_i)) ||
        (stack_ptr_two_wr_i && half1_q);
    wire spw_w = stack_ptr_one_wr_i || stack_ptr_two_wr_i;
    always @(posedge clk_i)
    begin
        if (rst_i || pair_w)
        begin
            half1_q <= 1'b0;
            half2_q <= 1'b0;
        end
        else if (spw_w)
        begin
            half1_q <= stack_ptr_one_wr_i;
            half2_q <= stack_ptr_two_wr_i;
        end
        if (rst_i)
            sp_ok_q <= 1'b0;
        else if (spw_w)
            sp_ok_q <= pair_w;
    end
    // ------------------------------------------
    // properties
    // ------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("bad ack");
    property p_rd_zero;
        wb_ack_o |-> wb_dat_o[31:4] == 28'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("bad read");
    property p_take_gap;
        int_take_o |=> !int_take_o;
    endproperty
    a_take_gap: assert property (p_take_gap) else $error("take");
    property p_ie_off;
        int_take_o |-> !ie_flag_o;
    endproperty
    a_ie_off: assert property (p_ie_off) else $error("ie kept");
    property p_vec_set;
        int_take_o |-> vector_lo_o inside {4'h0, 4'h4, 4'h6, 4'h8, 4'hc, 4'he};
    endproperty
    a_vec_set: assert property (p_vec_set) else $error("vector");
    property p_boundary;
        int_take_o |-> $past(instr_end_i) || $past(cpu_halted_o);
    endproperty
    a_boundary: assert property (p_boundary) else $error("mid");
    property p_mask_ie;
        int_take_o && vector_lo_o != 4'h0 |-> saved_ie_o;
    endproperty
    a_mask_ie: assert property (p_mask_ie) else $error("ie off");
    property p_sp_gate;
        int_take_o |-> $past(sp_ok_q);
    endproperty
    a_sp_gate: assert property (p_sp_gate) else $error("sp");
    property p_halt_why;
        $rose(cpu_halted_o) |-> $past(halt_exec_i);
    endproperty
    a_halt_why: assert property (p_halt_why) else $error("halt");
    property p_wake;
        $fell(cpu_halted_o) && $past(ie_flag_o) |-> int_take_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake");
endmodule

bind mihu_top mihu_top_chk u_mihu_top_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .instr_end_i(instr_end_i),
    .halt_exec_i(halt_exec_i), .stack_ptr_one_wr_i(stack_ptr_one_wr_i),
    .stack_ptr_two_wr_i(stack_ptr_two_wr_i), .int_take_o(int_take_o),
    .vector_lo_o(vector_lo_o), .saved_ie_o(saved_ie_o),
    .ie_flag_o(ie_flag_o), .cpu_halted_o(cpu_halted_o));

// file: mihu_cpu_model.sv
// cpu core model: instruction boundaries and vector load.
// assumes the unit's take pulse and vector nibble on the same clock.
`timescale 1ns/1ps
module mihu_cpu_model
(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // from the unit
    input wire int_take_i,
    input wire [3:0] vector_lo_i,
    input wire cpu_halted_i,
    // to the unit and bench
    output wire instr_end_o,
    output wire [7:0] take_cnt_o,
    output wire [15:0] pc_o
);
    reg [1:0] phase_q;
    reg [7:0] take_cnt_q;
    reg [15:0] pc_q;
    assign instr_end_o = (phase_q == 2'h2) && !cpu_halted_i;
    assign take_cnt_o = take_cnt_q;
    assign pc_o = pc_q;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            phase_q <= 2'h0;
            take_cnt_q <= 8'h00;
            pc_q <= 16'h0000;
        end
        else
        begin
            phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
            if (int_take_i)
            begin
                take_cnt_q <= take_cnt_q + 8'h01;
                pc_q <= {12'h010, vector_lo_i};
            end
            else if (instr_end_o)
                pc_q <= pc_q + 16'h0001;
        end
    end
endmodule

// file: mihu_top_tb.sv
// self-checking bench for the interrupt and halt unit.
// assumes the cpu model and the bound checker.
`timescale 1ns/1ps
`include "mihu_consts.vh"
`define CHK(a, b) begin total_checks = total_checks + 1; \
    if ((a) !== (b)) begin fail_count = fail_count + 1; \
    $display("mismatch at %0t: got %h exp %h", $time, a, b); end end
module mihu_top_tb;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg cyc = 1'b0;
    reg stb = 1'b0;
    reg we = 1'b0;
    reg [17:0] adr = 18'h0;
    reg [31:0] wdat = 32'h0;
    reg [11:0] ev_q = 12'h0;
    reg [3:0] tap_q = 4'h0;
    reg [3:0] key_q = 4'h0;
    wire [31:0] rdat;
    wire ack, iend, take, sie, ief, halted, irq;
    wire [3:0] vlo;
    wire [7:0] tcnt;
    wire [15:0] pc;
    integer fail_count = 0;
    integer total_checks = 0;
    integer cyc_n = 0;
    integer i;
    integer k;
    reg [31:0] q;
    reg [7:0] n0;
    always #5 clk_i = ~clk_i;
    // ------------------------------------------
    // design and cpu model
    // ------------------------------------------
    mihu_top u_mihu_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .prog_timer_zero_i(ev_q[1:0]), .serial_done_i(ev_q[2]),
        .key_input_pins_i(key_q), .clk_tap_i(tap_q),
        .stopwatch_tick_i(ev_q[4:3]), .wdt_nmi_i(ev_q[5]),
        .instr_end_i(iend), .halt_exec_i(ev_q[6]), .ie_set_i(ev_q[7]),
        .ie_clr_i(ev_q[8]), .return_from_interrupt_i(ev_q[9]), .return_from_interrupt_flag_i(1'b1),
        .stack_ptr_one_wr_i(ev_q[10]), .stack_ptr_two_wr_i(ev_q[11]),
        .int_take_o(take), .vector_lo_o(vlo), .saved_ie_o(sie),
        .ie_flag_o(ief), .cpu_halted_o(halted), .irq_o(irq));
    mihu_cpu_model u_mihu_cpu_model (.clk_i(clk_i), .rst_i(rst_i),
        .int_take_i(take), .vector_lo_i(vlo), .cpu_halted_i(halted),
        .instr_end_o(iend), .take_cnt_o(tcnt), .pc_o(pc));
    // ------------------------------------------
    // tasks
    // ------------------------------------------
    function [15:0] midx(input integer m);
        midx = 16'hffe2 + 16'(m + (m > 2));
    endfunction
    function [3:0] mbits(input integer m);
        case (m)
            0: mbits = `MIHU_PT_BITS;
            1: mbits = `MIHU_SER_BITS;
            2: mbits = `MIHU_KEY_BITS;
            3: mbits = `MIHU_CT_BITS;
            default: mbits = `MIHU_SW_BITS;
        endcase
    endfunction
    task wb(input w, input [15:0] idx, input [3:0] d);
    begin
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {28'h0, d};
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    end
    endtask
    task rd(input [15:0] idx, input [3:0] e);
    begin
        wb(1'b0, idx, 4'h0);
        `CHK(q, ({28'h0, e}))
    end
    endtask
    task pulse(input [11:0] m);
    begin
        @(posedge clk_i);
        ev_q <= m;
        @(posedge clk_i);
        ev_q <= 12'h0;
    end
    endtask
    task expect_take(input [15:0] e);
    begin
        n0 = tcnt;
        i = 0;
        while (tcnt === n0 && i < 60)
        begin
            @(posedge clk_i);
            #1;
            i = i + 1;
        end
        `CHK(tcnt, n0 + 8'h01)
        `CHK(pc, e)
    end
    endtask
    task expect_none(input integer n);
    begin
        n0 = tcnt;
        repeat (n) @(posedge clk_i);
        #1;
        `CHK(tcnt, n0)
    end
    endtask
    task end_of_test;
    begin
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    always @(posedge clk_i)
    begin
        cyc_n = cyc_n + 1;
        if (cyc_n == 8000)
        begin
            fail_count = fail_count + 1;
            end_of_test;
        end
    end
    // ------------------------------------------
    // tests
    // ------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (k = 0; k < 5; k = k + 1)
        begin
            rd(midx(k), 4'h0);
            rd(midx(k) + 16'h10, 4'h0);
            wb(1'b1, midx(k), 4'hf);
            rd(midx(k), mbits(k));
        end
        rd(16'hff00, 4'h0);
        $display("test registers done");
        pulse(12'h09f);
        tap_q <= 4'hf;
        wb(1'b1, `MIHU_IDX_KEY_SEL, 4'h1);
        rd(`MIHU_IDX_CT_PEND, 4'h0);
        tap_q <= 4'h0;
        key_q <= 4'h1;
        expect_none(8);
        for (k = 0; k < 5; k = k + 1)
            rd(midx(k) + 16'h10, mbits(k));
        `CHK(irq, 1'b1)
        wb(1'b1, `MIHU_IDX_PT_PEND, 4'h1);
        rd(`MIHU_IDX_PT_PEND, 4'h2);
        for (k = 0; k < 5; k = k + 2)
            wb(1'b1, midx(k) + 16'h10, 4'hf);
        $display("test events done");
        pulse(12'h400);
        pulse(12'h800);
        expect_take(16'h0106);
        `CHK(ief, 1'b0)
        `CHK(sie, 1'b1)
        expect_none(8);
        pulse(12'h200);
        expect_take(16'h0106);
        wb(1'b1, `MIHU_IDX_SER_PEND, 4'h1);
        pulse(12'h080);
        expect_take(16'h010c);
        wb(1'b1, `MIHU_IDX_CT_PEND, 4'hf);
        wb(1'b1, `MIHU_IDX_CT_MASK, 4'h2);
        tap_q <= 4'h1;
        pulse(12'h080);
        tap_q <= 4'h0;
        expect_none(8);
        rd(`MIHU_IDX_CT_PEND, 4'h1);
        `CHK(irq, 1'b0)
        tap_q <= 4'h2;
        pulse(12'h000);
        tap_q <= 4'h0;
        expect_take(16'h010c);
        rd(`MIHU_IDX_CT_PEND, 4'h3);
        wb(1'b1, `MIHU_IDX_CT_PEND, 4'hf);
        $display("test priority done");
        pulse(12'h020);
        expect_take(16'h0100);
        pulse(12'h400);
        pulse(12'h020);
        expect_none(10);
        rd(`MIHU_IDX_CORE_STAT, 4'h8);
        pulse(12'h800);
        expect_take(16'h0100);
        $display("test watchdog done");
        wb(1'b1, `MIHU_IDX_SW_MASK, 4'h0);
        pulse(12'h080);
        pulse(12'h040);
        expect_none(4);
        `CHK(halted, 1'b1)
        pulse(12'h008);
        rd(`MIHU_IDX_SW_PEND, 4'h1);
        `CHK(halted, 1'b1)
        pulse(12'h002);
        expect_take(16'h0104);
        `CHK(halted, 1'b0)
        $display("test halt done");
        end_of_test;
    end
endmodule
